// [link_controller_pkg.sv]
package link_controller_pkg;
    localparam logic [7:0] FLAG_PATTERN = 8'h7E;
    localparam logic [7:0] ABORT_PATTERN = 8'h7F;
    localparam logic [7:0] MARK_IDLE = 8'hFF;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] CMP_FOUR_FIRST_RST = 8'hFE;
    localparam logic [7:0] CMP_FOUR_SECOND_RST = 8'hFF;
    localparam logic [7:0] CR_IGNORE_MASK = 8'hFD;
    localparam logic [7:0] CMP_ALL_MASK = 8'hFF;
    localparam logic [15:0] PRNG_RST = 16'h0000;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FLAG_RUN = 3'h6;
    localparam logic [2:0] MAX_RUN = 3'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int MODE1_EN_LSB = 4;
    localparam int MODE4_FILL_BIT = 4;
    localparam int MODE4_SEL_BIT = 5;
    localparam int MODE4_CR_BIT = 6;
    localparam int MODE4_SECOND_BIT = 7;
    localparam int EA_BIT = 0;
    localparam int ERR_ABORT_BIT = 0;
    localparam logic [1:0] ADDR_ONE = 2'h1;
    localparam logic [1:0] ADDR_TWO = 2'h2;
    localparam logic [1:0] ADDR_LONG = 2'h3;
    typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_DROP} rx_state_e;
    typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_CLOSE, TX_ABORT}
        tx_state_e;
endpackage : link_controller_pkg

// [link_controller.sv]
`timescale 1ns/1ps
module link_controller
    import link_controller_pkg::*;
#(
    parameter int TX_DEPTH = 16
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic prng_rd_lo,
    input wire logic prng_rd_hi,
    input wire logic prng_wr_lo,
    input wire logic prng_wr_hi,
    input wire logic [7:0] prng_wdata,
    output logic [15:0] prng_value,
    input wire logic [7:0] link_mode_reg_one,
    input wire logic [7:0] link_mode_reg_four,
    input wire logic [7:0] error_mask_reg,
    input wire logic addr_int_en,
    input wire logic cmp_wr,
    input wire logic cmp_second_sel,
    input wire logic [1:0] cmp_index,
    input wire logic [7:0] cmp_wdata,
    input wire logic rx_abort_cmd,
    input wire logic tx_abort_level,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    output logic rx_in_progress,
    output logic rx_end_pulse,
    output logic addr_event,
    output logic [1:0] addr_len,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output logic [7:0] rx_out_data,
    output logic rx_out_last,
    output logic rx_out_abort,
    input wire logic [7:0] err_clr,
    output logic [7:0] receive_error_register,
    output logic error_irq,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_last,
    input wire logic tx_in_fcs,
    input wire logic tx_bit_req,
    output logic tx_bit,
    input wire logic echo_valid,
    input wire logic echo_bit,
    output logic tx_abort_status
);
    localparam int AW = $clog2(TX_DEPTH);
    logic [15:0] prng_q;
    logic prng_run_q;
    logic prng_fb;
    logic prng_rd;
    assign prng_rd = prng_rd_lo | prng_rd_hi;
    assign prng_fb = ~(prng_q[15] ^ prng_q[14] ^ prng_q[12] ^ prng_q[3]);
    assign prng_value = prng_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prng_q <= PRNG_RST;
            prng_run_q <= 1'b1;
        end
        else if (clk_en)
        begin
            if (prng_wr_lo)
            begin
                prng_q[7:0] <= prng_wdata;
                prng_run_q <= ~prng_rd;
            end
            else if (prng_wr_hi)
            begin
                prng_q[15:8] <= prng_wdata;
                prng_run_q <= 1'b0;
            end
            else if (prng_rd)
                prng_run_q <= 1'b0;
            else if (prng_run_q)
                prng_q <= {prng_q[14:0], prng_fb};
        end
    end

    // address compare values
    logic [7:0] fcmp_q [4];
    logic [7:0] scmp_q [4];
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                fcmp_q[i] <= CMP_RST;
                scmp_q[i] <= CMP_RST;
            end
            fcmp_q[3] <= CMP_FOUR_FIRST_RST;
            scmp_q[3] <= CMP_FOUR_SECOND_RST;
        end
        else if (clk_en && cmp_wr)
        begin
            if (cmp_second_sel)
                scmp_q[cmp_index] <= cmp_wdata;
            else
                fcmp_q[cmp_index] <= cmp_wdata;
        end
    end

    // receive bit engine
    rx_state_e rx_state_q;
    logic [2:0] rones_q;
    logic [2:0] rnb_q;
    logic [7:0] rsh_q;
    logic [7:0] hold_q;
    logic hold_v_q;
    logic [1:0] nbytes_q;
    logic [7:0] first_q;
    logic rx_go, is_flag, is_abort, is_stuff, byte_done;
    logic [7:0] new_byte;
    logic [7:0] cr_mask;
    logic [3:0] ent_en;
    logic recog_en, hit, addr_ok, decide;
    logic push_v, push_last, push_abort, fifo_ready;
    assign rx_go = clk_en & rx_bit_valid;
    assign is_flag = rx_go & ~rx_bit & (rones_q == FLAG_RUN);
    assign is_abort = rx_go & rx_bit & (rones_q == FLAG_RUN);
    assign is_stuff = ~rx_bit & (rones_q == STUFF_RUN);
    assign byte_done = rx_go & ~is_flag & ~is_abort & ~is_stuff
        & (rnb_q == LAST_BIT);
    assign new_byte = {rx_bit, rsh_q[7:1]};
    assign ent_en = link_mode_reg_one[MODE1_EN_LSB +: 4];
    assign recog_en = |ent_en;
    assign cr_mask = link_mode_reg_four[MODE4_CR_BIT] ? CMP_ALL_MASK
        : CR_IGNORE_MASK;
    assign decide = byte_done & (rx_state_q == RX_FRAME)
        & (nbytes_q == ADDR_ONE);

    always_comb
    begin
        hit = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            if (ent_en[i])
            begin
                if (!link_mode_reg_four[MODE4_SEL_BIT])
                    hit = hit | ((((first_q ^ fcmp_q[i]) & cr_mask) == CMP_RST)
                        & (new_byte == scmp_q[i]));
                else if (link_mode_reg_four[MODE4_SECOND_BIT])
                    hit = hit | (new_byte == scmp_q[i]);
                else
                    hit = hit
                        | (((first_q ^ fcmp_q[i]) & cr_mask) == CMP_RST);
            end
        end
    end
    assign addr_ok = ~recog_en | hit;

    // one byte is held back so the closing flag can mark the last one
    always_comb
    begin
        push_v = 1'b0;
        push_last = 1'b0;
        push_abort = 1'b0;
        if (rx_state_q == RX_FRAME && hold_v_q)
        begin
            if (is_abort || (clk_en && rx_abort_cmd))
            begin
                push_v = 1'b1;
                push_last = 1'b1;
                push_abort = 1'b1;
            end
            else if (is_flag)
            begin
                push_v = 1'b1;
                push_last = 1'b1;
            end
            else if (byte_done)
                push_v = (nbytes_q != ADDR_ONE) | addr_ok;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rones_q <= '0;
        else if (rx_go)
            rones_q <= !rx_bit ? 3'h0 : (rones_q == MAX_RUN) ? MAX_RUN
                : rones_q + 3'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_state_q <= RX_HUNT;
            rnb_q <= '0;
            rsh_q <= '0;
            hold_q <= '0;
            hold_v_q <= 1'b0;
            nbytes_q <= '0;
            first_q <= '0;
            rx_in_progress <= 1'b0;
            rx_end_pulse <= 1'b0;
            addr_event <= 1'b0;
            addr_len <= '0;
        end
        else if (clk_en)
        begin
            rx_end_pulse <= 1'b0;
            addr_event <= 1'b0;
            if (rx_abort_cmd || is_abort)
            begin
                rx_state_q <= RX_HUNT;
                rx_in_progress <= 1'b0;
                rx_end_pulse <= (rx_state_q != RX_HUNT);
                hold_v_q <= 1'b0;
            end
            else if (is_flag)
            begin
                rx_state_q <= RX_FRAME;
                rx_end_pulse <= (rx_state_q != RX_HUNT) && rx_in_progress;
                rx_in_progress <= 1'b0;
                rnb_q <= '0;
                nbytes_q <= '0;
                hold_v_q <= 1'b0;
            end
            else if (rx_go && !is_stuff && rx_state_q != RX_HUNT)
            begin
                rsh_q <= new_byte;
                rnb_q <= rnb_q + 3'h1;
                if (byte_done)
                begin
                    hold_q <= new_byte;
                    hold_v_q <= 1'b1;
                    if (nbytes_q != ADDR_TWO)
                        nbytes_q <= nbytes_q + 2'h1;
                    if (nbytes_q == '0)
                    begin
                        first_q <= new_byte;
                        rx_in_progress <= 1'b1;
                        addr_len <= new_byte[EA_BIT] ? ADDR_ONE : ADDR_TWO;
                    end
                    if (decide)
                    begin
                        if (!first_q[EA_BIT] && !new_byte[EA_BIT])
                            addr_len <= ADDR_LONG;
                        if (!addr_ok)
                            rx_state_q <= RX_DROP;
                        addr_event <= addr_ok && addr_int_en;
                    end
                end
            end
        end
    end

    // two-entry buffer toward the processor
    logic [9:0] fifo_q [2];
    logic fwp_q, frp_q;
    logic [1:0] fcnt_q;
    logic fpush, fpop;
    assign fifo_ready = (fcnt_q != 2'h2);
    assign fpush = clk_en & push_v & fifo_ready;
    assign fpop = clk_en & rx_out_valid & rx_out_ready;
    assign rx_out_valid = (fcnt_q != 2'h0);
    assign {rx_out_abort, rx_out_last, rx_out_data} = fifo_q[frp_q];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            fwp_q <= 1'b0;
            frp_q <= 1'b0;
            fcnt_q <= '0;
        end
        else
        begin
            if (fpush)
            begin
                fifo_q[fwp_q] <= {push_abort, push_last, hold_q};
                fwp_q <= ~fwp_q;
            end
            if (fpop)
                frp_q <= ~frp_q;
            fcnt_q <= fcnt_q + {1'b0, fpush} - {1'b0, fpop};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            receive_error_register <= '0;
        else if (clk_en)
        begin
            receive_error_register <= receive_error_register & ~err_clr;
            if (fpop && rx_out_last && rx_out_abort)
                receive_error_register[ERR_ABORT_BIT] <= 1'b1;
        end
    end
    assign error_irq = |(receive_error_register & error_mask_reg);

    // transmit frame store, kept until sent or aborted so a collision can resend it
    logic [8:0] tmem_q [TX_DEPTH];
    logic [AW:0] twp_q;
    logic [AW:0] trp_q;
    logic frame_rdy_q;
    tx_state_e tx_state_q;
    logic [2:0] tidx_q;
    logic [2:0] tones_q;
    logic [8:0] tcur_q;
    logic tx_go, tx_release, stuff_now, data_bit, collide;
    logic [7:0] pat;
    localparam logic [AW:0] TX_FULL = (AW+1)'(TX_DEPTH);
    assign tx_in_ready = ~frame_rdy_q & (twp_q != TX_FULL);
    assign tx_go = clk_en & tx_bit_req;
    assign stuff_now = (tones_q == STUFF_RUN);
    assign data_bit = tcur_q[8] ? tcur_q[3'h7 - tidx_q]
        : tcur_q[tidx_q];
    assign collide = clk_en & echo_valid & (echo_bit != tx_bit)
        & (tx_state_q != TX_IDLE) & (tx_state_q != TX_ABORT);
    assign tx_release = tx_go & (tidx_q == LAST_BIT)
        & (((tx_state_q == TX_CLOSE))
        | ((tx_state_q == TX_ABORT) & ~tx_abort_level));

    always_comb
    begin
        pat = MARK_IDLE;
        unique case (tx_state_q)
            TX_IDLE: pat = link_mode_reg_four[MODE4_FILL_BIT] ? FLAG_PATTERN
                : MARK_IDLE;
            TX_ABORT: pat = ABORT_PATTERN;
            TX_OPEN, TX_CLOSE: pat = FLAG_PATTERN;
            TX_DATA: pat = MARK_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            twp_q <= '0;
            frame_rdy_q <= 1'b0;
            for (int i = 0; i < TX_DEPTH; i++)
                tmem_q[i] <= '0;
        end
        else if (clk_en)
        begin
            if (tx_release)
            begin
                twp_q <= '0;
                frame_rdy_q <= 1'b0;
            end
            else if (tx_in_valid && tx_in_ready)
            begin
                tmem_q[twp_q[AW-1:0]] <= {tx_in_fcs, tx_in_data};
                twp_q <= twp_q + 1'b1;
                frame_rdy_q <= tx_in_last;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_state_q <= TX_IDLE;
            tidx_q <= '0;
            tones_q <= '0;
            tcur_q <= '0;
            trp_q <= '0;
            tx_bit <= 1'b1;
            tx_abort_status <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_abort_status <= 1'b0;
            if (tx_abort_level && tx_state_q != TX_ABORT)
            begin
                tx_state_q <= TX_ABORT;
                tidx_q <= '0;
            end
            else if (collide)
            begin
                tx_state_q <= TX_OPEN;
                tidx_q <= '0;
                trp_q <= '0;
            end
            else if (tx_go && tx_state_q == TX_DATA && stuff_now)
            begin
                tx_bit <= 1'b0;
                tones_q <= '0;
            end
            else if (tx_go)
            begin
                tidx_q <= tidx_q + 3'h1;
                if (tx_state_q == TX_DATA)
                begin
                    tx_bit <= data_bit;
                    tones_q <= data_bit ? tones_q + 3'h1 : 3'h0;
                end
                else
                begin
                    tx_bit <= pat[tidx_q];
                    tones_q <= '0;
                end
                if (tidx_q == LAST_BIT)
                begin
                    unique case (tx_state_q)
                        TX_IDLE:
                            if (frame_rdy_q)
                            begin
                                tx_state_q <= TX_OPEN;
                                trp_q <= '0;
                            end
                        TX_OPEN, TX_DATA:
                            if (trp_q == twp_q)
                                tx_state_q <= TX_CLOSE;
                            else
                            begin
                                tx_state_q <= TX_DATA;
                                tcur_q <= tmem_q[trp_q[AW-1:0]];
                                trp_q <= trp_q + 1'b1;
                            end
                        TX_CLOSE: tx_state_q <= TX_IDLE;
                        TX_ABORT:
                        begin
                            tx_abort_status <= 1'b1;
                            if (!tx_abort_level)
                                tx_state_q <= TX_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    chk_prng_reset_clear: assert property (
        @(posedge clk) !rst && $past(rst) |-> prng_value == PRNG_RST)
        else $error("counter not cleared at reset release");
    chk_prng_read_halt: assert property (
        @(posedge clk) disable iff (rst)
        clk_en && prng_rd && !prng_wr_lo |=> !clk_en || $stable(prng_value))
        else $error("counter moved after a read");
    chk_prng_lo_load: assert property (
        @(posedge clk) disable iff (rst)
        clk_en && prng_wr_lo && !prng_rd
        |=> prng_value[7:0] == $past(prng_wdata) && prng_run_q)
        else $error("low byte write did not load and run");
    chk_prng_runs_free: assert property (
        @(posedge clk) disable iff (rst)
        clk_en && prng_run_q && !prng_rd && !prng_wr_lo && !prng_wr_hi
        |=> prng_value != $past(prng_value))
        else $error("running counter did not step");
    chk_rx_abort_end: assert property (
        @(posedge clk) disable iff (rst)
        is_abort && rx_state_q != RX_HUNT |=> rx_end_pulse && !rx_in_progress)
        else $error("seven ones did not end the frame");
    chk_abort_err_read: assert property (
        @(posedge clk) disable iff (rst)
        fpop && rx_out_last && rx_out_abort
        |=> receive_error_register[ERR_ABORT_BIT])
        else $error("abort error bit not set on last byte read");
    chk_rx_cmd_abort: assert property (
        @(posedge clk) disable iff (rst)
        clk_en && rx_abort_cmd |=> rx_state_q == RX_HUNT)
        else $error("receive abort command ignored");
    chk_tx_abort_zero: assert property (
        @(posedge clk) disable iff (rst)
        tx_abort_status |-> !tx_bit && $past(tx_bit))
        else $error("abort pattern not closed by a zero");
    chk_tx_zero_stuff: assert property (
        @(posedge clk) disable iff (rst)
        tx_go && tx_state_q == TX_DATA && stuff_now && !collide
        && !tx_abort_level |=> !tx_bit)
        else $error("no zero after five ones");
    chk_mark_idle: assert property (
        @(posedge clk) disable iff (rst)
        tx_go && tx_state_q == TX_IDLE && !tx_abort_level
        && !link_mode_reg_four[MODE4_FILL_BIT] |=> tx_bit)
        else $error("mark idle sent a zero");
endmodule : link_controller

// [line_unit_model.sv]
`timescale 1ns/1ps
module line_unit_model (
    input wire logic clk,
    input wire logic tx_bit,
    output logic rx_bit_valid,
    output logic rx_bit,
    output logic tx_bit_req,
    output logic echo_valid,
    output logic echo_bit
);
    logic [24:0] txs = '0;
    int ones = 0;
    int flip_n = 0;
    initial
    begin
        rx_bit_valid = 1'h0;
        rx_bit = 1'h1;
        tx_bit_req = 1'h0;
        echo_valid = 1'h0;
        echo_bit = 1'h1;
    end
    // one d bit per valid pulse, line shows the inverse once released
    task send_bit(input logic b);
        @(posedge clk);
        rx_bit_valid <= 1'h1;
        rx_bit <= b;
        @(posedge clk);
        rx_bit_valid <= 1'h0;
        rx_bit <= ~b;
    endtask : send_bit
    // flags and abort runs go out without stuffing
    task send_raw(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++)
            send_bit(v[i]);
        ones = 0;
    endtask : send_raw
    task send_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            send_bit(v[i]);
            ones = v[i] ? ones + 1 : 0;
            if (ones == 5)
            begin
                send_bit(1'h0);
                ones = 0;
            end
        end
    endtask : send_byte
    // pull bits, echo each one back, inverted on the pull where flip_n is 1
    task pull(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tx_bit_req <= 1'h1;
            @(posedge clk);
            tx_bit_req <= 1'h0;
            @(negedge clk);
            txs = {txs[23:0], tx_bit};
            @(posedge clk);
            echo_valid <= 1'h1;
            echo_bit <= tx_bit ^ (flip_n == 1);
            flip_n = (flip_n > 0) ? flip_n - 1 : 0;
            @(posedge clk);
            echo_valid <= 1'h0;
            echo_bit <= ~tx_bit;
        end
    endtask : pull
endmodule : line_unit_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic clk = '0, rst = '1, clk_en = '1, tx_in_fcs = '0, tx_in_last = '0;
    logic prng_rd_lo = '0, prng_rd_hi = '0, prng_wr_lo = '0, prng_wr_hi = '0;
    logic addr_int_en = '1, cmp_wr = '0, cmp_second_sel = '0, rx_abort_cmd = '0;
    logic tx_abort_level = '0, tx_in_valid = '0, rx_out_ready = '0;
    logic [1:0] cmp_index = '0, addr_len;
    logic [7:0] prng_wdata = '0, link_mode_reg_one = '0, link_mode_reg_four = '0;
    logic [7:0] error_mask_reg = 8'h01, cmp_wdata = '0, err_clr = '0;
    logic [7:0] tx_in_data = '0, rx_out_data, receive_error_register;
    logic rx_bit_valid, rx_bit, tx_bit_req, echo_valid, echo_bit, tx_bit;
    logic rx_in_progress, rx_end_pulse, addr_event, rx_out_valid, rx_out_last;
    logic rx_out_abort, error_irq, tx_in_ready, tx_abort_status;
    logic [15:0] prng_value, v;
    logic [31:0] t[7] = '{32'h20FCFF01, 32'h2010FF00, 32'h2042FF01,
        32'h60FCFF00, 32'hA010FF01, 32'h00FE0100, 32'h00FEFF01};
    int error_cnt = 0, cmp_count = 0, n_addr = 0, n_end = 0, n_abt = 0, a0;
    logic [9:0] q[$];
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        n_addr <= n_addr + addr_event;
        n_end <= n_end + rx_end_pulse;
        n_abt <= n_abt + tx_abort_status;
        if (rx_out_valid && rx_out_ready)
            q.push_back({rx_out_abort, rx_out_last, rx_out_data});
    end
    link_controller #(.TX_DEPTH(4)) u_dut (.clk, .rst, .clk_en, .prng_rd_lo,
        .prng_rd_hi, .prng_wr_lo, .prng_wr_hi, .prng_wdata, .prng_value,
        .link_mode_reg_one, .link_mode_reg_four, .error_mask_reg, .addr_int_en,
        .cmp_wr, .cmp_second_sel, .cmp_index, .cmp_wdata, .rx_abort_cmd,
        .tx_abort_level, .rx_bit_valid, .rx_bit, .rx_in_progress, .rx_end_pulse,
        .addr_event, .addr_len, .rx_out_valid, .rx_out_ready, .rx_out_data,
        .rx_out_last, .rx_out_abort, .err_clr, .receive_error_register,
        .error_irq, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_in_last,
        .tx_in_fcs, .tx_bit_req, .tx_bit, .echo_valid, .echo_bit,
        .tx_abort_status);
    line_unit_model u_lu (.clk, .tx_bit, .rx_bit_valid, .rx_bit, .tx_bit_req,
        .echo_valid, .echo_bit);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wrap_up;
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task frame(input logic [7:0] a, b, c, input int n);
        u_lu.send_raw(8'h7E, 8);
        u_lu.send_byte(a);
        u_lu.send_byte(b);
        if (n > 2)
            u_lu.send_byte(c);
        u_lu.send_raw(n == 7 ? 8'hFF : 8'h7E, 8);
        repeat (30) @(posedge clk);
    endtask : frame
    initial
    begin
        repeat (12) @(posedge clk);
        chk(prng_value, 16'h0000);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        chk(prng_value !== 16'h0000, 1);
        chk({tx_in_ready, tx_bit}, 2'h3);
        prng_wdata <= 8'hAB;
        prng_wr_hi <= 1'h1;
        @(posedge clk);
        prng_wr_hi <= 1'h0;
        @(negedge clk);
        v = prng_value;
        chk(v[15:8], 8'hAB);
        repeat (3) @(negedge clk);
        chk(prng_value, v);
        @(posedge clk);
        prng_wdata <= 8'hCD;
        prng_wr_lo <= 1'h1;
        @(posedge clk);
        prng_wr_lo <= 1'h0;
        @(negedge clk);
        chk(prng_value, 16'hABCD);
        @(negedge clk);
        chk(prng_value !== 16'hABCD, 1);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            prng_wr_lo <= 1'h1;
            @(posedge clk);
            prng_wr_lo <= 1'h0;
            {prng_rd_hi, prng_rd_lo} <= 2'h1 << i;
            @(posedge clk);
            {prng_rd_hi, prng_rd_lo} <= 2'h0;
            @(negedge clk);
            v = prng_value;
            repeat (3) @(negedge clk);
            chk(prng_value, v);
        end
        $display("test prng done");
        frame(8'h02, 8'h03, 8'h00, 2);
        chk(addr_len, 2'h2);
        chk(n_addr, 1);
        chk(rx_out_valid, 1);
        rx_out_ready <= 1'h1;
        repeat (4) @(posedge clk);
        chk({q[0], q[1]}, 20'h00903);
        link_mode_reg_one <= 8'h90;
        cmp_wdata <= 8'h40;
        cmp_wr <= 1'h1;
        @(posedge clk);
        cmp_wr <= 1'h0;
        for (int i = 0; i < 7; i++)
        begin
            q.delete();
            a0 = n_addr;
            link_mode_reg_four <= t[i][31:24];
            frame(t[i][23:16], t[i][15:8], 8'h55, 3);
            chk(q.size(), t[i][0] ? 3 : 0);
            chk(n_addr - a0, t[i][0]);
        end
        chk({q[1], q[2]}, 20'h3FD55);
        link_mode_reg_one <= 8'h00;
        addr_int_en <= 1'h0;
        a0 = n_end;
        v = n_addr;
        frame(8'h11, 8'h03, 8'h55, 7);
        chk(n_end - a0, 1);
        chk(n_addr - v, 0);
        chk(q[$][9], 1);
        chk({receive_error_register[0], error_irq}, 2'h3);
        error_mask_reg <= 8'h00;
        @(posedge clk);
        chk({receive_error_register[0], error_irq}, 2'h2);
        err_clr <= 8'h01;
        @(posedge clk);
        err_clr <= 8'h00;
        @(negedge clk);
        chk({receive_error_register[0], error_irq}, 2'h0);
        u_lu.send_raw(8'h7E, 8);
        u_lu.send_byte(8'h11);
        u_lu.send_byte(8'h03);
        a0 = n_end;
        rx_abort_cmd <= 1'h1;
        @(posedge clk);
        rx_abort_cmd <= 1'h0;
        repeat (5) @(posedge clk);
        chk({rx_in_progress, n_end - a0 == 1}, 2'h1);
        $display("test rx done");
        for (int f = 0; f < 2; f++)
        begin
            @(posedge clk);
            link_mode_reg_four <= f << 4;
            tx_in_data <= 8'hFF;
            tx_in_last <= 1'h1;
            tx_in_valid <= 1'h1;
            @(posedge clk);
            tx_in_valid <= 1'h0;
            u_lu.flip_n = f * 18;
            for (a0 = 0; a0 < 80 && u_lu.txs !== 25'h0FDF77E; a0++)
                u_lu.pull(1);
            chk(u_lu.txs, 25'h0FDF77E);
            chk(a0, f ? 43 : 33);
            if (u_lu.txs !== 25'h0FDF77E)
                wrap_up();
            u_lu.pull(8);
            chk(u_lu.txs[7:0], f ? 8'h7E : 8'hFF);
        end
        tx_abort_level <= 1'h1;
        a0 = n_abt;
        u_lu.pull(16);
        chk(u_lu.txs[15:0], 16'hFEFE);
        chk(n_abt - a0, 2);
        tx_abort_level <= 1'h0;
        $display("test tx done");
        wrap_up();
    end
endmodule : tb_top
